// File: core/gpc_params.svh
// Constants for the output pin configuration register bank
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH
`define GPC_ADDR_PIN_TWO 6'h00
`define GPC_ADDR_PIN_ONE 6'h01
`define GPC_ADDR_PIN_ZERO 6'h02
`define GPC_ADDR_STROBE_LO 6'h30
`define GPC_ADDR_STROBE_HI 6'h3D
`define GPC_RST_PIN_TWO 8'h29
`define GPC_RST_PIN_ONE 8'h2E
`define GPC_RST_PIN_ZERO 8'h3F
`define GPC_SEL_CHIP_READY_LOW 6'h29
`define GPC_SEL_TRISTATE 6'h2E
`define GPC_SEL_XOSC_DIV 6'h3F
`define GPC_BIT_TOP 7
`define GPC_BIT_INV 6
`define GPC_XOSC_DIV 192
`define GPC_HDR_RW 7
`define GPC_HDR_BURST 6
`endif

// File: core/gpc_pkg.sv
// Types for the output pin configuration register bank
package gpc_pkg;
  typedef struct packed {
    logic top;
    logic invert;
    logic [5:0] func_sel;
  } gpc_pin_cfg_t;
  typedef struct packed {
    logic read;
    logic burst;
    logic [5:0] addr;
  } gpc_header_t;
  typedef enum logic [1:0] {
    GPC_ST_HEADER = 2'b00,
    GPC_ST_DATA = 2'b01
  } gpc_state_t;
endpackage

// File: core/gpc_regs.sv
// SPI slave holding the three output pin configuration registers
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_regs #(
  parameter int XOSC_DIV = `GPC_XOSC_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic crystal_osc_clock,
  input wire logic chip_ready_low,
  input wire logic [7:0] status_rdata,
  output logic [5:0] status_addr,
  output logic strobe_pulse,
  output logic [5:0] strobe_addr,
  output logic output_pin_two,
  output logic output_pin_two_oe,
  output logic output_pin_one,
  output logic output_pin_one_oe,
  output logic output_pin_zero,
  output logic output_pin_zero_oe,
  output logic output_pin_drive_strength,
  output logic temp_sensor_enable
);
  // The toggle divider only gives the full ratio for even values
  if (XOSC_DIV < 2 || XOSC_DIV > 1024 || XOSC_DIV % 2 != 0) begin : g_bad_div
    $error("XOSC_DIV out of range");
  end

  // Register each pin three times; stage two gives the levels, stages two and three give the edges
  logic [3:0] s1_q, s2_q, s3_q;
  always_ff @(posedge clk) begin
    s1_q <= {spi_sclk, spi_cs_n, spi_mosi, crystal_osc_clock};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  logic cs_n, mosi, xosc, sclk_rise, sclk_fall, cs_fall;
  assign cs_n = s2_q[2];
  assign mosi = s2_q[1];
  assign xosc = s2_q[0];
  assign sclk_rise = s2_q[3] & ~s3_q[3];
  assign sclk_fall = ~s2_q[3] & s3_q[3];
  assign cs_fall = ~s2_q[2] & s3_q[2];

  // Stays out of the sleep domain: only rst touches these
  gpc_pkg::gpc_pin_cfg_t pin_two_q, pin_one_q, pin_zero_q;
  gpc_pkg::gpc_pin_cfg_t pin_two_d, pin_one_d, pin_zero_d;
  gpc_pkg::gpc_state_t st_q, st_d;
  gpc_pkg::gpc_header_t hdr_q, hdr_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d;
  logic [5:0] addr_q, addr_d;
  logic miso_q, miso_d, stb_q, stb_d;

  function automatic logic is_upper(input logic [5:0] a);
    is_upper = (a >= `GPC_ADDR_STROBE_LO) && (a <= `GPC_ADDR_STROBE_HI);
  endfunction

  function automatic logic [7:0] read_reg(input logic [5:0] a, input logic burst,
                                          input gpc_pkg::gpc_pin_cfg_t p2,
                                          input gpc_pkg::gpc_pin_cfg_t p1,
                                          input gpc_pkg::gpc_pin_cfg_t p0,
                                          input logic [7:0] stat);
    read_reg = 8'h00;
    if (a == `GPC_ADDR_PIN_TWO) read_reg = {1'b0, p2[6:0]};
    else if (a == `GPC_ADDR_PIN_ONE) read_reg = p1;
    else if (a == `GPC_ADDR_PIN_ZERO) read_reg = p0;
    else if (is_upper(a) && burst) read_reg = stat;
  endfunction

  logic [7:0] sh_next;
  assign sh_next = {sh_q[6:0], mosi};
  assign status_addr = addr_q;

  always_comb begin
    st_d = st_q;
    hdr_d = hdr_q;
    bit_d = bit_q;
    sh_d = sh_q;
    tx_d = tx_q;
    addr_d = addr_q;
    miso_d = miso_q;
    stb_d = 1'b0;
    pin_two_d = pin_two_q;
    pin_one_d = pin_one_q;
    pin_zero_d = pin_zero_q;
    if (cs_n) begin
      st_d = gpc_pkg::GPC_ST_HEADER;
      bit_d = 3'h0;
      miso_d = 1'b0;
    end else if (cs_fall) begin
      bit_d = 3'h0;
      miso_d = 1'b0;
    end else if (sclk_rise) begin
      sh_d = sh_next;
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        if (st_q == gpc_pkg::GPC_ST_HEADER) begin
          hdr_d = sh_next;
          addr_d = sh_next[5:0];
          st_d = gpc_pkg::GPC_ST_DATA;
          // Upper region without burst bit acts as a one-byte command strobe
          if (is_upper(sh_next[5:0]) && !sh_next[`GPC_HDR_BURST]) begin
            stb_d = 1'b1;
            st_d = gpc_pkg::GPC_ST_HEADER;
          end
        end else begin
          if (!hdr_q.read) begin
            if (addr_q == `GPC_ADDR_PIN_TWO) pin_two_d = {1'b0, sh_next[6:0]};
            if (addr_q == `GPC_ADDR_PIN_ONE) pin_one_d = sh_next;
            if (addr_q == `GPC_ADDR_PIN_ZERO) pin_zero_d = sh_next;
          end
          // Burst walks forward through the lower region
          if (hdr_q.burst && !is_upper(addr_q)) addr_d = addr_q + 6'h01;
          else if (!hdr_q.burst) st_d = gpc_pkg::GPC_ST_HEADER;
        end
      end
    end else if (sclk_fall) begin
      miso_d = 1'b0;
      if (st_q == gpc_pkg::GPC_ST_DATA && hdr_q.read) begin
        // Fetch at the last fall of the previous byte: status_addr then already names the new address
        if (bit_q == 3'h0) begin
          tx_d = read_reg(addr_q, hdr_q.burst, pin_two_q, pin_one_q, pin_zero_q,
                          status_rdata);
          miso_d = tx_d[7];
        end else begin
          miso_d = tx_q[3'h7 - bit_q];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= gpc_pkg::GPC_ST_HEADER;
      hdr_q <= '0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= 6'h00;
      miso_q <= 1'b0;
      stb_q <= 1'b0;
      pin_two_q <= `GPC_RST_PIN_TWO;
      pin_one_q <= `GPC_RST_PIN_ONE;
      pin_zero_q <= `GPC_RST_PIN_ZERO;
    end else begin
      st_q <= st_d;
      hdr_q <= hdr_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      addr_q <= addr_d;
      miso_q <= miso_d;
      stb_q <= stb_d;
      pin_two_q <= pin_two_d;
      pin_one_q <= pin_one_d;
      pin_zero_q <= pin_zero_d;
    end
  end
  assign spi_miso = miso_q;
  assign strobe_pulse = stb_q;
  assign strobe_addr = addr_q;

  // Divider of the sampled oscillator level; rate limited by clk sampling
  logic [9:0] div_q, div_d;
  logic div_out_q, div_out_d, xosc_q;
  always_comb begin
    div_d = div_q;
    div_out_d = div_out_q;
    if (xosc & ~xosc_q) begin
      if (div_q == 10'(XOSC_DIV / 2 - 1)) begin
        div_d = 10'h000;
        div_out_d = ~div_out_q;
      end else begin
        div_d = div_q + 10'h001;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 10'h000;
      div_out_q <= 1'b0;
      xosc_q <= 1'b0;
    end else begin
      div_q <= div_d;
      div_out_q <= div_out_d;
      xosc_q <= xosc;
    end
  end

  // Selector decode; codes outside this bank's knowledge drive the invert bit level
  function automatic logic [1:0] pin_mux(input gpc_pkg::gpc_pin_cfg_t c, input logic rdy_n,
                                         input logic dclk);
    logic v;
    v = 1'b0;
    case (c.func_sel)
      `GPC_SEL_CHIP_READY_LOW: v = rdy_n;
      `GPC_SEL_XOSC_DIV: v = dclk;
      default: v = 1'b0;
    endcase
    pin_mux = {c.func_sel != `GPC_SEL_TRISTATE, v ^ c.invert};
  endfunction

  logic [1:0] m2, m1, m0;
  logic rdy_q;
  always_ff @(posedge clk) begin
    if (rst) rdy_q <= 1'b1;
    else rdy_q <= chip_ready_low;
  end
  assign m2 = pin_mux(pin_two_q, rdy_q, div_out_q);
  assign m1 = pin_mux(pin_one_q, rdy_q, div_out_q);
  assign m0 = pin_mux(pin_zero_q, rdy_q, div_out_q);
  assign output_pin_two = m2[0];
  assign output_pin_two_oe = m2[1];
  assign output_pin_one = m1[0];
  assign output_pin_one_oe = m1[1];
  assign output_pin_zero = m0[0];
  assign output_pin_zero_oe = m0[1];
  assign output_pin_drive_strength = pin_one_q.top;
  assign temp_sensor_enable = pin_zero_q.top;
endmodule

// File: sim/gpc_regs_asserts.sv
// Port checks for the output pin configuration bank
`timescale 1ns/1ps
module gpc_regs_asserts (
  input logic clk,
  input logic rst,
  input logic chip_ready_low,
  input logic strobe_pulse,
  input logic [5:0] strobe_addr,
  input logic output_pin_two,
  input logic output_pin_two_oe,
  input logic output_pin_one_oe,
  input logic output_pin_zero_oe,
  input logic output_pin_drive_strength,
  input logic temp_sensor_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_released; $past(rst); endsequence
  sequence s_ready_steady; $stable(chip_ready_low) [*4]; endsequence
  a_strobe_single: assert property (strobe_pulse |=> !strobe_pulse)
    else $error("strobe pulse too long");
  a_strobe_upper: assert property (strobe_pulse |-> strobe_addr inside {[6'h30:6'h3D]})
    else $error("strobe outside upper region");
  a_pin_one_hiz: assert property (s_released |-> !output_pin_one_oe)
    else $error("pin one driven after reset");
  a_drive_low: assert property (s_released |-> !output_pin_drive_strength)
    else $error("drive strength high after reset");
  a_temp_off: assert property (s_released |-> !temp_sensor_enable)
    else $error("temperature sensor on after reset");
  a_two_driven: assert property (s_released |-> output_pin_two_oe)
    else $error("pin two not driven after reset");
  a_zero_driven: assert property (s_released |-> output_pin_zero_oe)
    else $error("pin zero not driven after reset");
  a_ready_follow: assert property ($fell(rst) ##0 s_ready_steady
    |-> output_pin_two == chip_ready_low)
    else $error("pin two does not show chip ready");
endmodule
bind gpc_regs gpc_regs_asserts chk (.clk, .rst, .chip_ready_low, .strobe_pulse, .strobe_addr,
  .output_pin_two, .output_pin_two_oe, .output_pin_one_oe, .output_pin_zero_oe,
  .output_pin_drive_strength, .temp_sensor_enable);

// File: sim/gpc_host.sv
// Host model acting as mode 0 serial master
`timescale 1ns/1ps
module gpc_host (
  input logic clk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input logic spi_miso
);
  int half = 6;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Clock idles low between frames; a released data line flips so stale bits never match
  task automatic sel(input logic lvl);
    repeat (half) @(negedge clk);
    spi_cs_n = lvl;
    if (lvl) spi_mosi = ~spi_mosi;
    repeat (half) @(negedge clk);
  endtask
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = tx[i];
      repeat (half) @(negedge clk);
      spi_sclk = 1'b1;
      rx[i] = spi_miso;
      repeat (half) @(negedge clk);
      spi_sclk = 1'b0;
    end
  endtask
endmodule

// File: sim/gpc_regs_tb.sv
// Self-checking bench for the output pin configuration bank
`timescale 1ns/1ps
module gpc_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic crl = 1'b1;
  logic xosc = 1'b0;
  logic sclk, cs_n, mosi, miso, p2, p0, ds, temp, strobe;
  logic p1, p2_oe, p1_oe, p0_oe;
  logic [5:0] saddr, st_addr, last_strobe;
  logic [7:0] r, srd;
  logic [7:0] exp3 [3] = '{8'h45, 8'h80, 8'h80};
  int bad_count = 0;
  int compares = 0;
  int n_strobe = 0;
  longint t0;
  always #5 clk = ~clk;
  always #20 xosc = ~xosc;
  // Status side model: each status register reads back its own address with a marker
  assign srd = {2'b10, saddr};
  always @(posedge clk) if (strobe) begin
    last_strobe <= st_addr;
    n_strobe <= n_strobe + 1;
  end
  gpc_host host (.clk(clk), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso));
  gpc_regs #(.XOSC_DIV(4)) dut (.clk(clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso), .crystal_osc_clock(xosc), .chip_ready_low(crl),
    .status_rdata(srd), .status_addr(saddr), .strobe_pulse(strobe),
    .strobe_addr(st_addr), .output_pin_two(p2), .output_pin_two_oe(p2_oe),
    .output_pin_one(p1), .output_pin_one_oe(p1_oe), .output_pin_zero(p0),
    .output_pin_zero_oe(p0_oe), .output_pin_drive_strength(ds), .temp_sensor_enable(temp));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.sel(1'b0);
    host.shift({2'b00, a}, r);
    host.shift(d, r);
    host.sel(1'b1);
  endtask
  task automatic rd(input logic [7:0] hdr, input logic [7:0] exp);
    host.sel(1'b0);
    host.shift(hdr, r);
    host.shift(8'h00, r);
    host.sel(1'b1);
    chk(r, exp);
  endtask
  task automatic restart_and_defaults;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rd(8'h80, 8'h29);
    rd(8'h81, 8'h2E);
    rd(8'h82, 8'h3F);
    chk({5'h00, p2_oe, p1_oe, p0_oe}, 8'h05);
    $display("test defaults done");
  endtask
  task automatic final_report;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #500_000;
    bad_count++;
    final_report();
  end
  initial begin
    restart_and_defaults();
    @(posedge p0);
    t0 = $time;
    @(posedge p0);
    @(negedge clk);
    chk(8'(($time - t0) / 10), 8'h10);
    wr(6'h00, 8'h69);
    wr(6'h01, 8'h29);
    chk({5'h00, p2_oe, p1_oe, p0_oe}, 8'h07);
    for (int v = 0; v < 2; v++) begin
      crl = v[0];
      repeat (4) @(negedge clk);
      chk({6'h00, p2, p1}, {6'h00, ~crl, crl});
    end
    $display("test invert done");
    crl = 1'b1;
    host.sel(1'b0);
    host.shift(8'h40, r);
    host.shift(8'hC5, r);
    host.shift(8'h80, r);
    host.shift(8'h80, r); // Sensor on, other bits zero, clock output off
    host.sel(1'b1);
    chk({6'h00, ds, temp}, 8'h03);
    $display("test write done");
    wr(6'h05, 8'hFF);
    rd(8'h85, 8'h00);
    host.half = 12;
    host.sel(1'b0);
    host.shift(8'hC0, r);
    for (int i = 0; i < 3; i++) begin
      host.shift(8'h00, r);
      chk(r, exp3[i]);
    end
    host.sel(1'b1);
    host.half = 6;
    $display("test burst done");
    for (int a = 8'h30; a <= 8'h3D; a++) begin
      rd({2'b11, a[5:0]}, {2'b10, a[5:0]});
      host.sel(1'b0);
      host.shift({2'b00, a[5:0]}, r);
      host.sel(1'b1);
      chk({2'b00, last_strobe}, {2'b00, a[5:0]});
    end
    chk(n_strobe[7:0], 8'h0E);
    $display("test upper region done");
    restart_and_defaults();
    final_report();
  end
endmodule
